// ==== logic/sbt_timer.sv ====
// Sixteen-bit timer/counter with AHB-Lite register access.
// How it works
// - Wide-access bit set makes count reads and writes one sixteen-bit operation.
// - Two-bit select routes this counter or companion timer to both compare units.
// - Prescale field divides the input clock by one, two, four or eight.
// - External clock is synchronised unless sync-disable is set; ignored for internal clock.
// - External source counts from the first rising edge after a falling edge.
// - Internal source advances each instruction cycle; external on each rising edge.
// - Counting happens only while the on bit is one.
// - Oscillator enable forces both oscillator pins to inputs reading zero.
// - Count wraps from FFFF to 0000 and sets the overflow flag.
// - Interrupt request raised only when the overflow enable bit is set.
// - Special event trigger match in mode 1011 resets the count to zero.
// - Trigger reset does not set the overflow flag.
// - A software count write wins over a coincident trigger reset.
// - Trigger reset is reliable only in timer or synchronised counter mode.
// - The compare pair acts as period so the count restarts at each match.
// - Low-power oscillator runs only while its enable bit is set.
module sbt_timer
(
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // External count sources.
  input wire logic external_count_pin,
  input wire logic lp_osc_in,
  // Oscillator pin port view.
  input wire logic [1:0] osc_pin_direction_bits,
  input wire logic [1:0] osc_pin_level,
  output logic [1:0] osc_pin_is_input,
  output logic [1:0] osc_pin_read,
  output logic lp_osc_run,
  // Compare unit time base routing and interrupt.
  output logic first_compare_uses_main,
  output logic second_compare_uses_main,
  output logic overflow_irq,
  output logic [15:0] count_value
);
  // Register state.
  logic [7:0] counter_control;
  logic [15:0] count;
  logic [7:0] high_buffer;
  logic overflow_flag;
  logic overflow_irq_enable;
  logic low_power_osc_enable;
  logic [3:0] compare_mode_code;
  logic [15:0] compare_value_pair;
  logic [2:0] prescale_cnt;
  logic [1:0] instr_div;
  logic [1:0] osc_sync_a;
  logic [1:0] osc_sync_b;
  // Data phase capture.
  logic dp_valid;
  logic dp_write;
  logic [7:0] dp_addr;

  // Decoding of the address phase, and of the captured data phase for writes.
  wire addr_take = hsel && hready && htrans[sbt_pkg::HTRANS_ACTIVE_BIT];
  wire wr_ctrl = dp_valid && dp_write && dp_addr == sbt_pkg::ADDR_CONTROL;
  wire wr_low = dp_valid && dp_write && dp_addr == sbt_pkg::ADDR_COUNT_LOW;
  wire wr_high = dp_valid && dp_write && dp_addr == sbt_pkg::ADDR_COUNT_HIGH;
  wire wr_flags = dp_valid && dp_write && dp_addr == sbt_pkg::ADDR_FLAGS;
  wire wr_enables = dp_valid && dp_write && dp_addr == sbt_pkg::ADDR_ENABLES;
  wire wr_system = dp_valid && dp_write && dp_addr == sbt_pkg::ADDR_SYSTEM;
  wire rd_low_take = addr_take && !hwrite && haddr == sbt_pkg::ADDR_COUNT_LOW;

  // Control fields.
  wire wide_access_enable = counter_control[sbt_pkg::BIT_WIDE_ACCESS];
  wire time_base_select_hi = counter_control[sbt_pkg::BIT_TB_SELECT_HI];
  wire time_base_select_lo = counter_control[sbt_pkg::BIT_TB_SELECT_LO];
  wire [1:0] prescale_sel = {counter_control[sbt_pkg::BIT_PRESCALE_HI], counter_control[sbt_pkg::BIT_PRESCALE_LO]};
  wire sync_disable = counter_control[sbt_pkg::BIT_SYNC_DISABLE];
  wire clock_source_select = counter_control[sbt_pkg::BIT_CLOCK_SOURCE];
  wire counter_on = counter_control[sbt_pkg::BIT_COUNTER_ON];

  // Input tick: instruction cycle or external edge.
  logic ext_tick;
  wire instr_tick = instr_div == sbt_pkg::INSTR_DIV_LAST;
  wire in_tick = clock_source_select ? ext_tick : instr_tick;

  // Prescaler terminal test, a divide by 2^sel.
  function automatic logic prescale_done(input logic [2:0] cnt, input logic [1:0] sel);
    logic [2:0] mask;
    mask = 3'(( 4'h1 << sel) - 4'h1);
    return (cnt & mask) == mask;
  endfunction : prescale_done

  wire count_tick = counter_on && in_tick && prescale_done(prescale_cnt, prescale_sel);
  wire wrap = count_tick && count == 16'hFFFF;
  wire special_event = compare_mode_code == sbt_pkg::MODE_SPECIAL_EVENT;
  wire match = special_event && count == compare_value_pair && (first_compare_uses_main);
  // Unsynchronised counter mode cannot honour the trigger reliably.
  wire trig_reset = match && !(clock_source_select && sync_disable);
  wire count_write = wr_low || (wr_high && !wide_access_enable);

  // The edge detector forgets a seen falling edge whenever external counting stops.
  wire arm_clear = !clock_source_select || !counter_on;

  // External edge source.
  sbt_edge_source u_edge
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .external_count_pin(external_count_pin),
    .lp_osc_in(lp_osc_in),
    .lp_osc_enable(low_power_osc_enable),
    .sync_disable(sync_disable),
    .armed_clear(arm_clear),
    .ext_tick(ext_tick)
  );

  // Bus data phase tracking.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
    end
    else
    begin
      dp_valid <= addr_take;
      dp_write <= hwrite;
      dp_addr <= haddr;
    end
  end

  // Control and configuration registers.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      counter_control <= sbt_pkg::CONTROL_RESET;
      overflow_irq_enable <= 1'b0;
      low_power_osc_enable <= 1'b0;
      compare_mode_code <= sbt_pkg::COMPARE_MODE_RESET;
      compare_value_pair <= 16'h0000;
    end
    else
    begin
      if (wr_ctrl)
        counter_control <= hwdata[7:0];
      if (wr_enables)
        overflow_irq_enable <= hwdata[sbt_pkg::BIT_OVERFLOW];
      if (wr_system)
      begin
        low_power_osc_enable <= hwdata[sbt_pkg::BIT_LP_OSC_ENABLE];
        compare_mode_code <= hwdata[sbt_pkg::POS_COMPARE_MODE +: 4];
        compare_value_pair <= hwdata[sbt_pkg::POS_COMPARE_VALUE +: 16];
      end
    end
  end

  // Instruction clock divider and prescaler.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      instr_div <= 2'h0;
      prescale_cnt <= 3'h0;
    end
    else
    begin
      instr_div <= instr_div + 2'h1;
      if (wr_low || wr_ctrl)
        prescale_cnt <= 3'h0;
      else if (counter_on && in_tick)
        prescale_cnt <= prescale_cnt + 3'h1;
    end
  end

  // The count itself; a software write beats a trigger reset, which beats a tick.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      count <= 16'h0000;
    end
    else
    begin
      if (wr_low)
        count <= wide_access_enable ? {high_buffer, hwdata[7:0]} : {count[15:8], hwdata[7:0]};
      else if (wr_high && !wide_access_enable)
        count[15:8] <= hwdata[7:0];
      else if (trig_reset)
        count <= 16'h0000;
      else if (count_tick)
        count <= count + 16'h0001;
    end
  end

  // Wide-mode high byte buffer: loaded by high writes, refreshed from the count by low reads.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      high_buffer <= 8'h00;
    else if (wr_high && wide_access_enable)
      high_buffer <= hwdata[7:0];
    else if (rd_low_take && wide_access_enable)
      high_buffer <= count[15:8];
  end

  // Overflow flag: set wins over a coincident clear, and trigger resets never set it.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      overflow_flag <= 1'b0;
    else if (wrap && !count_write && !trig_reset)
      overflow_flag <= 1'b1;
    else if (wr_flags && !hwdata[sbt_pkg::BIT_OVERFLOW])
      overflow_flag <= 1'b0;
  end

  // Oscillator pin synchronisers.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      osc_sync_a <= 2'h0;
      osc_sync_b <= 2'h0;
    end
    else
    begin
      osc_sync_a <= osc_pin_level;
      osc_sync_b <= osc_sync_a;
    end
  end

  // Read data selection.
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (haddr)
      sbt_pkg::ADDR_CONTROL: rd_mux[7:0] = counter_control;
      sbt_pkg::ADDR_COUNT_LOW: rd_mux[7:0] = count[7:0];
      sbt_pkg::ADDR_COUNT_HIGH: rd_mux[7:0] = wide_access_enable ? high_buffer : count[15:8];
      sbt_pkg::ADDR_FLAGS: rd_mux[sbt_pkg::BIT_OVERFLOW] = overflow_flag;
      sbt_pkg::ADDR_ENABLES: rd_mux[sbt_pkg::BIT_OVERFLOW] = overflow_irq_enable;
      sbt_pkg::ADDR_SYSTEM:
      begin
        rd_mux[sbt_pkg::BIT_LP_OSC_ENABLE] = low_power_osc_enable;
        rd_mux[sbt_pkg::POS_COMPARE_MODE +: 4] = compare_mode_code;
        rd_mux[sbt_pkg::POS_COMPARE_VALUE +: 16] = compare_value_pair;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Bus response: read data launched at the address phase, so it stands in the data phase.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      if (addr_take && !hwrite)
        hrdata <= rd_mux;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Oscillator pin view; the oscillator claims both pins as inputs while it runs.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      osc_pin_is_input <= 2'h0;
      osc_pin_read <= 2'h0;
      lp_osc_run <= 1'b0;
    end
    else
    begin
      osc_pin_is_input <= low_power_osc_enable ? 2'h3 : osc_pin_direction_bits;
      osc_pin_read <= low_power_osc_enable ? 2'h0 : osc_sync_b;
      lp_osc_run <= low_power_osc_enable;
    end
  end

  // Time base routing, interrupt request and the visible count, one cycle behind the state.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      first_compare_uses_main <= 1'b0;
      second_compare_uses_main <= 1'b0;
      overflow_irq <= 1'b0;
      count_value <= 16'h0000;
    end
    else
    begin
      first_compare_uses_main <= time_base_select_hi;
      second_compare_uses_main <= time_base_select_hi || time_base_select_lo;
      overflow_irq <= overflow_flag && overflow_irq_enable;
      count_value <= count;
    end
  end
endmodule : sbt_timer

// ==== shared/sbt_pkg.sv ====
// Package with register map, field positions and reset values of the sixteen-bit timer/counter.
package sbt_pkg;
  // Register byte addresses on the AHB-Lite slave.
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'h04;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h08;
  localparam logic [7:0] ADDR_FLAGS = 8'h0C;
  localparam logic [7:0] ADDR_ENABLES = 8'h10;
  localparam logic [7:0] ADDR_SYSTEM = 8'h14;
  // Field positions in counter_control.
  localparam int BIT_WIDE_ACCESS = 7;
  localparam int BIT_TB_SELECT_HI = 6;
  localparam int BIT_PRESCALE_HI = 5;
  localparam int BIT_PRESCALE_LO = 4;
  localparam int BIT_TB_SELECT_LO = 3;
  localparam int BIT_SYNC_DISABLE = 2;
  localparam int BIT_CLOCK_SOURCE = 1;
  localparam int BIT_COUNTER_ON = 0;
  // Overflow flag and enable position in the flag and enable registers.
  localparam int BIT_OVERFLOW = 1;
  // Positions in the system register (compare pair control and oscillator enable).
  localparam int BIT_LP_OSC_ENABLE = 3;
  localparam int POS_COMPARE_MODE = 4;
  localparam int POS_COMPARE_VALUE = 16;
  // Reset values.
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [3:0] COMPARE_MODE_RESET = 4'h0;
  // Compare mode code for special event trigger.
  localparam logic [3:0] MODE_SPECIAL_EVENT = 4'hB;
  // Quarter-rate instruction clock divider.
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
  // AHB transfer type bit that marks an active transfer.
  localparam int HTRANS_ACTIVE_BIT = 1;
endpackage : sbt_pkg

// ==== logic/sbt_edge_source.sv ====
// Source selection, synchronisation and rising-edge detect for the external count input.
module sbt_edge_source
(
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Raw external inputs.
  input wire logic external_count_pin,
  input wire logic lp_osc_in,
  // Control.
  input wire logic lp_osc_enable,
  input wire logic sync_disable,
  input wire logic armed_clear,
  // Result.
  output logic ext_tick
);
  logic raw_sel;
  logic sync_a;
  logic sync_b;
  logic sync_c;
  logic prev;
  logic seen_low;
  logic cur;

  // Oscillator feeds the counter only while it runs, else the pin.
  assign raw_sel = lp_osc_enable ? lp_osc_in : external_count_pin;

  // Two-stage synchroniser, then one alignment stage that only the synchronised mode uses.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
    end
    else
    begin
      sync_a <= raw_sel;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // Unsynchronised mode skips the alignment stage and sees each edge one cycle sooner.
  assign cur = sync_disable ? sync_b : sync_c;

  // First count only on a rising edge after a falling edge has been seen.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prev <= 1'b0;
      seen_low <= 1'b0;
      ext_tick <= 1'b0;
    end
    else
    begin
      prev <= cur;
      if (armed_clear)
        seen_low <= 1'b0;
      else if (prev && !cur)
        seen_low <= 1'b1;
      ext_tick <= seen_low && !prev && cur;
    end
  end
endmodule : sbt_edge_source

// ==== verification/sbt_ext_clock.sv ====
// Behavioural model of the external count source that drives the pin or the low-power oscillator line.
module sbt_ext_clock
(
  // Control from the bench.
  input wire logic run,
  input wire logic use_osc,
  // Clock lines into the timer.
  output logic external_count_pin,
  output logic lp_osc_in,
  // Rising edges that the timer should have counted.
  output logic [15:0] rises
);
  timeunit 1ns;
  timeprecision 100ps;
  logic level = 1'b0;
  logic armed = 1'b0;
  initial rises = 16'h0000;
  // The clock rests low outside a burst, so its first edge is a rise that must not count.
  always #27
  begin
    if (run)
    begin
      level = ~level;
      if (!level)
        armed = 1'b1;
      else if (armed)
        rises = rises + 16'h0001;
    end
    else
    begin
      level = 1'b0;
      armed = 1'b0;
    end
  end
  // Only the selected line carries the clock; the other rests low.
  assign external_count_pin = use_osc ? 1'b0 : level;
  assign lp_osc_in = use_osc ? level : 1'b0;
endmodule : sbt_ext_clock

// ==== verification/sbt_timer_asserts.sv ====
// Concurrent checks on the ports of the sixteen-bit timer/counter.
module sbt_timer_asserts
(
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Bus inputs.
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  // Observed outputs.
  input wire logic [1:0] osc_pin_is_input,
  input wire logic [1:0] osc_pin_read,
  input wire logic lp_osc_run,
  input wire logic first_compare_uses_main,
  input wire logic second_compare_uses_main,
  input wire logic overflow_irq,
  input wire logic [15:0] count_value
);
  timeunit 1ns;
  timeprecision 100ps;
  logic wr_dp;
  logic [7:0] wr_addr;
  logic [7:0] ctl;
  logic irq_en;
  logic [6:0] age;
  logic [6:0] gap;
  logic quiet;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // Shadows control and enable writes, and counts cycles since the last write and the last count change.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_dp <= 1'b0;
      wr_addr <= 8'h00;
      ctl <= 8'h00;
      irq_en <= 1'b0;
      age <= 7'h00;
      gap <= 7'h00;
    end
    else
    begin
      wr_dp <= hsel && hready && htrans[sbt_pkg::HTRANS_ACTIVE_BIT] && hwrite;
      wr_addr <= haddr;
      if (wr_dp && wr_addr == sbt_pkg::ADDR_CONTROL)
        ctl <= hwdata[7:0];
      if (wr_dp && wr_addr == sbt_pkg::ADDR_ENABLES)
        irq_en <= hwdata[sbt_pkg::BIT_OVERFLOW];
      age <= wr_dp ? 7'h00 : (age == 7'h7F ? age : age + 7'h01);
      gap <= $changed(count_value) ? 7'h01 : (gap == 7'h7F ? gap : gap + 7'h01);
    end
  end
  // No write has touched the count for the last two cycles.
  assign quiet = !wr_dp && age >= 7'h02;
  AST_ROUTE: assert property ($stable(ctl) |-> first_compare_uses_main == ctl[6] &&
    second_compare_uses_main == (ctl[6] || ctl[3])) else $error("Time base routing wrong.");
  AST_OSC_PINS: assert property (lp_osc_run && $past(lp_osc_run) |->
    osc_pin_is_input == 2'b11 && osc_pin_read == 2'b00) else $error("Oscillator pins not inputs reading zero.");
  AST_STEP: assert property (quiet && $changed(count_value) |->
    count_value == $past(count_value) + 16'h0001 || count_value == 16'h0000) else $error("Count jumped.");
  AST_STOPPED: assert property (quiet && !ctl[0] && !$past(ctl[0]) && !$past(ctl[0], 2) |->
    $stable(count_value)) else $error("Count moved while stopped.");
  AST_RATE: assert property (age >= 7'd100 && ctl[1:0] == 2'b01 && $changed(count_value) &&
    count_value > 16'h0001 |-> gap == (7'd4 << ctl[5:4])) else $error("Internal tick period wrong.");
  AST_IRQ_EN: assert property (overflow_irq |-> $past(irq_en)) else $error("Request without enable.");
  AST_WRAP_FLAG: assert property (quiet && irq_en && $past(count_value) == 16'hFFFF &&
    count_value == 16'h0000 |-> ##[0:3] overflow_irq) else $error("Wrap raised no request.");
  AST_TRIG_NO_FLAG: assert property (quiet && irq_en && !overflow_irq && count_value == 16'h0000 &&
    $past(count_value) != 16'hFFFF && $past(count_value) != 16'h0000 |=> (!overflow_irq) [*3])
    else $error("Trigger reset raised a request.");
endmodule : sbt_timer_asserts
bind sbt_timer sbt_timer_asserts u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .osc_pin_is_input(osc_pin_is_input),
  .osc_pin_read(osc_pin_read), .lp_osc_run(lp_osc_run), .first_compare_uses_main(first_compare_uses_main),
  .second_compare_uses_main(second_compare_uses_main), .overflow_irq(overflow_irq), .count_value(count_value));

// ==== verification/sbt_timer_tb.sv ====
// Self-checking testbench for the sixteen-bit timer/counter.
module sbt_timer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b1;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd_data;
  logic hreadyout, hresp, ext_pin, osc_in, osc_run, first_main, second_main, irq;
  logic run = 1'b0;
  logic use_osc = 1'b0;
  logic [1:0] dir_bits = 2'b01;
  logic [1:0] pin_level = 2'b10;
  logic [1:0] is_input, pin_read;
  logic [15:0] count, rises, v0, base;
  int mismatches = 0;
  int compares = 0;
  // Free-running 200 MHz clock.
  always #2.5 hclk = ~hclk;
  sbt_timer DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .external_count_pin(ext_pin), .lp_osc_in(osc_in), .osc_pin_direction_bits(dir_bits),
    .osc_pin_level(pin_level), .osc_pin_is_input(is_input), .osc_pin_read(pin_read), .lp_osc_run(osc_run),
    .first_compare_uses_main(first_main), .second_compare_uses_main(second_main), .overflow_irq(irq),
    .count_value(count));
  sbt_ext_clock u_ext (.run(run), .use_osc(use_osc), .external_count_pin(ext_pin), .lp_osc_in(osc_in),
    .rises(rises));
  // One single AHB-Lite transfer, entered just after a rising edge.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hwrite <= wr;
    haddr <= a;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_data = hrdata;
  endtask : xfer
  // Compares a seen value with the expected one and reports a difference.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t ns: got %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  // Prints the verdict and ends the run.
  task automatic tally_and_finish;
    if (mismatches == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  // Cuts a hung run short.
  initial
  begin
    #60us;
    mismatches++;
    tally_and_finish;
  end
  // Main test sequence.
  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b0, sbt_pkg::ADDR_CONTROL, 32'h0);
    chk(rd_data, {24'h0, sbt_pkg::CONTROL_RESET});
    chk({hreadyout, hresp}, 2'b10);
    xfer(1'b0, 8'h20, 32'h0);
    chk(rd_data, 32'h0);
    for (int s = 0; s < 4; s++)
    begin
      xfer(1'b1, sbt_pkg::ADDR_CONTROL, {25'h0, s[1], 2'b00, s[0], 3'b000});
      repeat (3) @(posedge hclk);
      chk({first_main, second_main}, {s[1], s[1] | s[0]});
    end
    xfer(1'b1, sbt_pkg::ADDR_CONTROL, 32'h00);
    xfer(1'b1, sbt_pkg::ADDR_COUNT_HIGH, 32'h12);
    xfer(1'b1, sbt_pkg::ADDR_COUNT_LOW, 32'h34);
    repeat (20) @(posedge hclk);
    chk(count, 16'h1234);
    // Ten prescaled periods must give exactly ten counts.
    for (int p = 0; p < 4; p++)
    begin
      xfer(1'b1, sbt_pkg::ADDR_CONTROL, 32'h01 | (p << 4));
      repeat (100) @(posedge hclk);
      v0 = count;
      repeat (40 << p) @(posedge hclk);
      chk(16'(count - v0), 16'd10);
    end
    // Wide mode: the high byte passes through the buffer.
    xfer(1'b1, sbt_pkg::ADDR_CONTROL, 32'h80);
    repeat (2) @(posedge hclk);
    v0 = count;
    xfer(1'b1, sbt_pkg::ADDR_COUNT_HIGH, 32'h55);
    repeat (2) @(posedge hclk);
    chk(count, v0);
    xfer(1'b1, sbt_pkg::ADDR_COUNT_LOW, 32'hFF);
    repeat (2) @(posedge hclk);
    chk(count, 16'h55FF);
    xfer(1'b0, sbt_pkg::ADDR_COUNT_LOW, 32'h0);
    xfer(1'b1, sbt_pkg::ADDR_CONTROL, 32'h81);
    repeat (12) @(posedge hclk);
    xfer(1'b1, sbt_pkg::ADDR_CONTROL, 32'h80);
    xfer(1'b0, sbt_pkg::ADDR_COUNT_HIGH, 32'h0);
    chk(rd_data[7:0], 8'h55);
    xfer(1'b0, sbt_pkg::ADDR_COUNT_LOW, 32'h0);
    xfer(1'b0, sbt_pkg::ADDR_COUNT_HIGH, 32'h0);
    chk(rd_data[7:0], 8'h56);
    xfer(1'b1, sbt_pkg::ADDR_CONTROL, 32'h00);
    // Overflow with the request enabled, then disabled.
    for (int e = 1; e >= 0; e--)
    begin
      xfer(1'b1, sbt_pkg::ADDR_ENABLES, e << 1);
      xfer(1'b1, sbt_pkg::ADDR_COUNT_HIGH, 32'hFF);
      xfer(1'b1, sbt_pkg::ADDR_COUNT_LOW, 32'hFE);
      xfer(1'b1, sbt_pkg::ADDR_CONTROL, 32'h01);
      repeat (30) @(posedge hclk);
      chk(irq, e);
      xfer(1'b0, sbt_pkg::ADDR_FLAGS, 32'h0);
      chk(rd_data[1], 1'b1);
      xfer(1'b1, sbt_pkg::ADDR_CONTROL, 32'h00);
      xfer(1'b1, sbt_pkg::ADDR_FLAGS, 32'h0);
      repeat (3) @(posedge hclk);
      xfer(1'b0, sbt_pkg::ADDR_FLAGS, 32'h0);
      chk({irq, rd_data[1]}, 2'b00);
    end
    // Compare value 0x0010 in trigger mode, with and without routing to the first unit.
    xfer(1'b1, sbt_pkg::ADDR_ENABLES, 32'h2);
    xfer(1'b1, sbt_pkg::ADDR_SYSTEM, 32'h001000B0);
    for (int t = 0; t < 2; t++)
    begin
      xfer(1'b1, sbt_pkg::ADDR_COUNT_HIGH, 32'h0);
      xfer(1'b1, sbt_pkg::ADDR_COUNT_LOW, 32'h0);
      xfer(1'b1, sbt_pkg::ADDR_CONTROL, t ? 32'h41 : 32'h09);
      v0 = 16'h0000;
      repeat (200)
      begin
        @(posedge hclk);
        if (count > v0)
          v0 = count;
      end
      chk(v0 < 16'h0011, t);
      chk(irq, 1'b0);
    end
    xfer(1'b1, sbt_pkg::ADDR_SYSTEM, 32'h0);
    xfer(1'b1, sbt_pkg::ADDR_CONTROL, 32'h00);
    // External bursts: synchronised pin, unsynchronised pin, oscillator line.
    for (int m = 0; m < 3; m++)
    begin
      use_osc <= (m == 2);
      xfer(1'b1, sbt_pkg::ADDR_SYSTEM, (m == 2) ? 32'h8 : 32'h0);
      xfer(1'b1, sbt_pkg::ADDR_CONTROL, (m == 1) ? 32'h07 : 32'h03); // The system clock is never the oscillator.
      repeat (10) @(posedge hclk);
      v0 = count;
      base = rises;
      run <= 1'b1;
      repeat (120) @(posedge hclk);
      run <= 1'b0;
      repeat (20) @(posedge hclk);
      chk(16'(count - v0), 16'(rises - base));
      if (m == 2)
        chk({osc_run, is_input, pin_read}, 5'b11100);
      xfer(1'b1, sbt_pkg::ADDR_CONTROL, 32'h00); // Stopping re-arms the first-edge rule.
    end
    xfer(1'b1, sbt_pkg::ADDR_SYSTEM, 32'h0);
    repeat (4) @(posedge hclk);
    chk({osc_run, is_input, pin_read}, 5'b00110);
    tally_and_finish;
  end
endmodule : sbt_timer_tb
